//--- core/bfs_clkgen.sv
// switching-cycle tick: follows external sync edges, else internal divider
`timescale 1ns/1ps
module bfs_clkgen
  import bfs_pkg::*;
#(
  parameter int DIV_W = 16,
  parameter int LOSS_CYC = SYNC_LOSS_CYC
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic sync_s,
  input wire logic [DIV_W-1:0] osc_div,
  output logic cycle_tick,
  output logic ext_locked
);
  logic sync_d_r;
  logic [DIV_W-1:0] osc_cnt_r;
  logic [DIV_W:0] loss_cnt_r;
  logic sync_rise;
  logic osc_wrap;

  assign sync_rise = sync_s & ~sync_d_r;
  assign osc_wrap = (osc_cnt_r >= osc_div - DIV_W'(1));

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) sync_d_r <= 1'b0;
    else sync_d_r <= sync_s;
  end

  // lock drops when no sync edge arrives within the loss window
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      loss_cnt_r <= '0;
      ext_locked <= 1'b0;
    end else if (sync_rise) begin
      loss_cnt_r <= '0;
      ext_locked <= 1'b1;
    end else if (loss_cnt_r >= (DIV_W+1)'(LOSS_CYC)) begin
      ext_locked <= 1'b0;
    end else begin
      loss_cnt_r <= loss_cnt_r + 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) osc_cnt_r <= '0;
    else if (osc_wrap || (ext_locked && sync_rise)) osc_cnt_r <= '0;
    else osc_cnt_r <= osc_cnt_r + 1'b1;
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) cycle_tick <= 1'b0;
    else cycle_tick <= ext_locked ? sync_rise : osc_wrap;
  end
endmodule

//--- core/bfs_pkg.sv
// constants and types shared by the buck fault supervisor
package bfs_pkg;
  localparam int CLK_FREQ_HZ = 100_000_000;
  localparam int CLK_PERIOD_NS = 10;
  // power-good rise delay at 1 ms soft-start, in us
  localparam int PG_RISE_DLY_US = 200;
  localparam int PG_RISE_DLY_CYC = (PG_RISE_DLY_US * 1000) / CLK_PERIOD_NS;
  // power-good fall delay on shutdown, in us
  localparam int PG_FALL_DLY_US = 10;
  localparam int PG_FALL_DLY_CYC = (PG_FALL_DLY_US * 1000) / CLK_PERIOD_NS;
  // undervoltage qualification time, in us
  localparam int UV_DLY_US = 10;
  localparam int UV_DLY_CYC = (UV_DLY_US * 1000) / CLK_PERIOD_NS;
  // consecutive switching cycles with overcurrent that force shutdown
  localparam int OC_TRIP_COUNT = 4;
  // hiccup wait default, cycles (no printed figure)
  localparam int HICCUP_CYC_DEF = 1_000_000;
  // soft-start durations in ms
  localparam int SS_1MS = 1;
  localparam int SS_3MS = 3;
  localparam int SS_6MS = 6;
  localparam int SS_CYC_PER_MS = CLK_FREQ_HZ / 1000;
  // internal oscillator frequency range, kHz: 1.5 MHz .. 250 kHz
  localparam int OSC_MIN_KHZ = 250;
  localparam int OSC_MAX_KHZ = 1500;
  localparam int OSC_DIV_DEF = CLK_FREQ_HZ / (600 * 1000);
  // sync pulse missing for longer than this falls back to internal osc
  localparam int SYNC_LOSS_CYC = CLK_FREQ_HZ / (OSC_MIN_KHZ * 1000) * 2;

  typedef enum logic [1:0] {OCL_4A5, OCL_6A, OCL_9A} bfs_oclim_t;
  typedef enum logic [1:0] {SST_1MS, SST_3MS, SST_6MS} bfs_ss_t;
  typedef enum logic [2:0] {
    ST_OFF, ST_SOFTSTART, ST_RUN, ST_OV_CLAMP, ST_TRISTATE, ST_HICCUP, ST_OT_WAIT
  } bfs_state_t;

  function automatic logic [31:0] bfs_ss_cycles(input bfs_ss_t s);
    case (s)
      SST_3MS: bfs_ss_cycles = 32'(SS_3MS * SS_CYC_PER_MS);
      SST_6MS: bfs_ss_cycles = 32'(SS_6MS * SS_CYC_PER_MS);
      default: bfs_ss_cycles = 32'(SS_1MS * SS_CYC_PER_MS);
    endcase
  endfunction
endpackage

//--- core/bfs_supervisor.sv
// buck converter fault and sequencing supervisor, top level
`timescale 1ns/1ps
module bfs_supervisor
  import bfs_pkg::*;
#(
  parameter int HICCUP_CYC = HICCUP_CYC_DEF,
  parameter int SS_MS_CYC = SS_CYC_PER_MS,
  parameter int DIV_W = 16
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic enable_pin,
  input wire logic input_lockout,
  input wire logic vin_above_1v,
  input wire logic hs_over_limit,
  input wire logic ls_over_limit,
  input wire logic fb_over_window,
  input wire logic fb_under_window,
  input wire logic over_temp,
  input wire logic temp_recovered,
  input wire logic freq_set_sync_pin,
  input wire logic pwm_on_req,
  input wire bfs_oclim_t oc_limit_sel,
  input wire bfs_ss_t ss_sel,
  input wire logic [DIV_W-1:0] osc_div,
  output logic hs_gate,
  output logic ls_gate,
  output logic gates_tristate,
  output logic discharge_on,
  output logic supply_ok_flag_o,
  output logic supply_ok_flag_oe_n,
  output logic switching_active,
  output logic ss_active,
  output logic cycle_tick,
  output logic ext_sync_locked,
  output bfs_oclim_t oc_limit_active,
  output logic [2:0] overcurrent_event_cnt,
  output logic over_voltage_trip,
  output logic under_voltage_trip
);
  ////////////////////////////////////////////////////////////////////////
  // input synchronisers
  localparam int NS = 10;
  logic [NS-1:0] raw_in;
  logic [NS-1:0] syn;
  logic en_s, lock_s, vin1_s, hsoc_s, lsoc_s, ov_s, uv_s, ot_s, otok_s, sync_s;

  assign raw_in = {enable_pin, input_lockout, vin_above_1v, hs_over_limit, ls_over_limit,
                   fb_over_window, fb_under_window, over_temp, temp_recovered,
                   freq_set_sync_pin};
  bfs_sync2 #(.W(NS)) u_sync (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .d(raw_in),
    .q(syn)
  );
  assign {en_s, lock_s, vin1_s, hsoc_s, lsoc_s, ov_s, uv_s, ot_s, otok_s, sync_s} = syn;

  bfs_clkgen #(.DIV_W(DIV_W)) u_clk (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .sync_s(sync_s),
    .osc_div(osc_div),
    .cycle_tick(cycle_tick),
    .ext_locked(ext_sync_locked)
  );

  ////////////////////////////////////////////////////////////////////////
  // configuration latched on leaving off state
  bfs_ss_t ss_cfg_r;
  bfs_state_t state_r, state_nxt;
  logic [31:0] tmr_r;
  logic oc_shut, uv_shut, off_cond;
  logic [15:0] uv_cnt_r;
  logic hs_cut_r;
  logic [31:0] ss_len;

  // scale the selected duration by the per-ms count so short benches stay short
  assign ss_len = 32'(bfs_ss_cycles(ss_cfg_r) / 32'(SS_CYC_PER_MS) * 32'(SS_MS_CYC));

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      oc_limit_active <= OCL_6A;
      ss_cfg_r <= SST_1MS;
    end else if (state_r == ST_OFF) begin
      oc_limit_active <= oc_limit_sel;
      ss_cfg_r <= ss_sel;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // overcurrent counting
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) overcurrent_event_cnt <= '0;
    else if (state_r != ST_RUN && state_r != ST_SOFTSTART) overcurrent_event_cnt <= '0;
    else if (cycle_tick && hsoc_s) overcurrent_event_cnt <= overcurrent_event_cnt + 3'h1;
    else if (!hsoc_s && !hs_cut_r) overcurrent_event_cnt <= '0;
  end
  assign oc_shut = (overcurrent_event_cnt >= 3'(OC_TRIP_COUNT)) || lsoc_s;

  // high-side stays cut until the next switching cycle starts
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) hs_cut_r <= 1'b0;
    else if (hsoc_s) hs_cut_r <= 1'b1;
    else if (cycle_tick) hs_cut_r <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // undervoltage timer
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) uv_cnt_r <= '0;
    else if (!uv_s || state_r != ST_RUN) uv_cnt_r <= '0;
    else if (uv_cnt_r < 16'(UV_DLY_CYC)) uv_cnt_r <= uv_cnt_r + 16'h1;
  end
  assign uv_shut = (uv_cnt_r >= 16'(UV_DLY_CYC));

  ////////////////////////////////////////////////////////////////////////
  // sequencing state machine
  assign off_cond = lock_s || !en_s;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_OFF: if (!off_cond && !ot_s) state_nxt = ST_SOFTSTART;
      ST_SOFTSTART, ST_RUN: begin
        if (state_r == ST_SOFTSTART && tmr_r >= ss_len - 32'h1)
          state_nxt = ST_RUN;
        if (ov_s) state_nxt = ST_OV_CLAMP;
        if (uv_shut) state_nxt = ST_TRISTATE;
        if (oc_shut) state_nxt = ST_HICCUP;
      end
      ST_OV_CLAMP: if (uv_s) state_nxt = ST_TRISTATE;
      ST_TRISTATE: state_nxt = ST_HICCUP;
      ST_HICCUP: if (tmr_r >= 32'(HICCUP_CYC) - 32'h1) state_nxt = ST_OFF;
      ST_OT_WAIT: if (otok_s && !ot_s) state_nxt = ST_OFF;
      default: state_nxt = ST_OFF;
    endcase
    if (ot_s && state_r != ST_OT_WAIT) state_nxt = ST_OT_WAIT;
    else if (off_cond && state_r != ST_OT_WAIT) state_nxt = ST_OFF;
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) state_r <= ST_OFF;
    else state_r <= state_nxt;
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) tmr_r <= '0;
    else if (state_nxt != state_r) tmr_r <= '0;
    else if (tmr_r != 32'hFFFF_FFFF) tmr_r <= tmr_r + 32'h1;
  end

  ////////////////////////////////////////////////////////////////////////
  // gate drive, discharge
  logic sw_on;
  assign sw_on = (state_r == ST_SOFTSTART) || (state_r == ST_RUN);

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      hs_gate <= 1'b0;
      ls_gate <= 1'b0;
      gates_tristate <= 1'b1;
      discharge_on <= 1'b0;
    end else begin
      hs_gate <= sw_on && pwm_on_req && !hs_cut_r && !hsoc_s && !oc_shut;
      ls_gate <= (sw_on && (!pwm_on_req || hs_cut_r || hsoc_s) && !oc_shut)
                 || (state_r == ST_OV_CLAMP && !uv_s);
      gates_tristate <= !(sw_on || state_r == ST_OV_CLAMP);
      discharge_on <= !en_s && vin1_s;
    end
  end
  assign switching_active = sw_on;
  assign ss_active = (state_r == ST_SOFTSTART);

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      over_voltage_trip <= 1'b0;
      under_voltage_trip <= 1'b0;
    end else begin
      over_voltage_trip <= (state_r == ST_OV_CLAMP);
      under_voltage_trip <= uv_shut;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // power-good with rise and fall delays
  logic in_window;
  logic pg_r;
  logic [15:0] pg_cnt_r;
  logic [15:0] pg_rise_cyc;
  assign in_window = sw_on && !ov_s && !uv_s;
  // rise delay is specified for the 1 ms soft-start; applied to all settings
  assign pg_rise_cyc = 16'(PG_RISE_DLY_CYC);

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      pg_r <= 1'b0;
      pg_cnt_r <= '0;
    end else if (in_window == pg_r) begin
      pg_cnt_r <= '0;
    end else if (!pg_r && pg_cnt_r >= pg_rise_cyc - 16'h1) begin
      pg_r <= 1'b1;
      pg_cnt_r <= '0;
    end else if (pg_r && pg_cnt_r >= 16'(PG_FALL_DLY_CYC) - 16'h1) begin
      pg_r <= 1'b0;
      pg_cnt_r <= '0;
    end else begin
      pg_cnt_r <= pg_cnt_r + 16'h1;
    end
  end
  // open drain: enable low pulls the pin low
  assign supply_ok_flag_o = 1'b0;
  assign supply_ok_flag_oe_n = pg_r;

  ////////////////////////////////////////////////////////////////////////
  // checks
  // the delay counter restarts whenever window and flag agree, so its end value is a run length
  a_pg_rise_delay: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    $rose(pg_r) |-> $past(in_window) && ($past(pg_cnt_r) == 16'(PG_RISE_DLY_CYC) - 16'h1))
    else $error("power good rose without full delay");
  a_pg_fall_delay: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    $fell(pg_r) |-> !$past(in_window) && ($past(pg_cnt_r) == 16'(PG_FALL_DLY_CYC) - 16'h1))
    else $error("power good fell too early");
  a_lockout_off: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    lock_s |=> !sw_on)
    else $error("switching while input locked out");
  a_lockout_restart: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    (state_r == ST_OFF && !off_cond && !ot_s) |=> state_r == ST_SOFTSTART)
    else $error("no restart after lockout cleared");
  a_hs_oc_cut: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    hsoc_s |=> !hs_gate)
    else $error("high side on during overcurrent");
  a_oc_count_trip: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    (sw_on && !off_cond && !ot_s && overcurrent_event_cnt >= 3'(OC_TRIP_COUNT))
      |=> state_r == ST_HICCUP)
    else $error("no shutdown at overcurrent count");
  a_ls_oc_both: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    (lsoc_s && sw_on) |=> !hs_gate && !ls_gate)
    else $error("switch on during low side overcurrent");
  a_uv_timer: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    (state_r == ST_RUN && !off_cond && !ot_s && uv_cnt_r == 16'(UV_DLY_CYC) && !oc_shut)
      |=> state_r == ST_TRISTATE)
    else $error("undervoltage did not tri-state");
  a_ov_clamp_low: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    (state_r == ST_OV_CLAMP && !uv_s) |=> ls_gate && !hs_gate)
    else $error("overvoltage clamp not driving low side");
  a_discharge_gate: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    !vin1_s |=> !discharge_on)
    else $error("discharge on with input below 1 V");
  a_pg_window: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    (pg_r && !in_window) |-> pg_cnt_r < 16'(PG_FALL_DLY_CYC))
    else $error("power good outside window");
endmodule

//--- core/bfs_sync2.sv
// two-flop synchroniser for a bundle of asynchronous levels
`timescale 1ns/1ps
module bfs_sync2 #(
  parameter int W = 1
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_r <= '0;
      q <= '0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule

//--- testbench/bfs_supervisor_bench.sv
// self-checking bench for the buck fault supervisor
`timescale 1ns/1ps
module bfs_supervisor_bench;
  import bfs_pkg::*;
  // short hiccup so repeated retries fit the run
  localparam int HIC = 200;
  localparam int DIV = 166;
  // short soft-start per ms so the run stays small
  localparam int SSC = 1000;
  logic pg_o;
  logic ref_clk, arst_n, en, lk, v1, hso, lso, fbo, fbu, ot, tr, pwm, run;
  logic hs, ls, tri_s, dis, pg_oe_n, sw_act, ss_act, tick, lock, syn, ovt, uvt;
  logic [2:0] occ;
  logic [15:0] div;
  bfs_oclim_t ocl, ocl_act;
  bfs_ss_t ss;
  int mismatches, compares, t0, c;
  int cyc = 0;

  bfs_sync_src src (.run(run), .sync_o(syn));
  bfs_supervisor #(.HICCUP_CYC(HIC), .SS_MS_CYC(SSC)) uut (
    .ref_clk(ref_clk), .arst_n(arst_n), .enable_pin(en), .input_lockout(lk),
    .vin_above_1v(v1), .hs_over_limit(hso), .ls_over_limit(lso), .fb_over_window(fbo),
    .fb_under_window(fbu), .over_temp(ot), .temp_recovered(tr), .freq_set_sync_pin(syn),
    .pwm_on_req(pwm), .oc_limit_sel(ocl), .ss_sel(ss), .osc_div(div), .hs_gate(hs),
    .ls_gate(ls), .gates_tristate(tri_s), .discharge_on(dis), .supply_ok_flag_o(pg_o),
    .supply_ok_flag_oe_n(pg_oe_n), .switching_active(sw_act), .ss_active(ss_act),
    .cycle_tick(tick), .ext_sync_locked(lock), .oc_limit_active(ocl_act),
    .overcurrent_event_cnt(occ), .over_voltage_trip(ovt), .under_voltage_trip(uvt));

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) cyc <= cyc + 1;

  ////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    $display("compares=%0d mismatches=%0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic got, input logic exp, input string m);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask

  task automatic chkn(input int got, input int lo, input int hi, input string m);
    compares++;
    if (got < lo || got > hi) begin
      mismatches++;
      $display("MISMATCH %0t %s took %0d", $time, m, got);
    end
  endtask

  function automatic logic sel(input int k);
    case (k)
      0: sel = pg_oe_n;
      1: sel = ss_act;
      3: sel = lock;
      4: sel = tri_s;
      5: sel = tick;
      default: sel = sw_act;
    endcase
  endfunction

  // a wait that runs out is itself a failed comparison
  task automatic upto(input int k, input logic v, input int n);
    c = 0;
    compares++;
    while (sel(k) !== v && c < n) begin
      @(negedge ref_clk);
      c++;
    end
    if (c >= n) begin
      mismatches++;
      $display("MISMATCH %0t wait ran out", $time);
      conclude();
    end
  endtask

  task automatic cy(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  task automatic ticks(input int n);
    repeat (n) begin
      upto(5, 1'b1, 2 * DIV);
      cy(1);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic t_off();
    chk(hs | ls, 1'b0, "gates off while disabled");
    chk(dis, 1'b1, "discharge while disabled");
    v1 = 1'b0;
    cy(5);
    chk(dis, 1'b0, "discharge at low input");
    v1 = 1'b1;
    for (int i = 0; i < 3; i++) begin
      ocl = bfs_oclim_t'(i);
      cy(5);
      chk(ocl_act === ocl, 1'b1, "limit select");
    end
    $display("t_off done");
  endtask

  task automatic t_sync();
    ticks(1);
    upto(5, 1'b1, 2 * DIV);
    chkn(c + 1, DIV - 1, DIV + 1, "internal period");
    run = 1'b1;
    upto(3, 1'b1, 2000);
    ticks(2);
    upto(5, 1'b1, 2 * DIV);
    chkn(c + 1, 98, 102, "sync period");
    run = 1'b0;
    upto(3, 1'b0, 2000);
    chkn(c, SYNC_LOSS_CYC - 200, SYNC_LOSS_CYC + 20, "sync loss");
    $display("t_sync done");
  endtask

  task automatic t_start();
    en = 1'b1;
    upto(1, 1'b1, 10);
    chkn(c, 2, 4, "start latency");
    upto(1, 1'b0, SSC + 100);
    chkn(c, SSC - 10, SSC + 10, "soft-start");
    chk(pg_oe_n, 1'b0, "pg outside window");
    fbu = 1'b0;
    upto(0, 1'b1, PG_RISE_DLY_CYC + 100);
    chkn(c, PG_RISE_DLY_CYC - 5, PG_RISE_DLY_CYC + 10, "pg rise");
    $display("t_start done");
  endtask

  task automatic t_uv();
    fbu = 1'b1;
    t0 = cyc;
    upto(0, 1'b0, 2000);
    chkn(cyc - t0, PG_FALL_DLY_CYC - 5, PG_FALL_DLY_CYC + 10, "pg fall");
    upto(4, 1'b1, 2000);
    chkn(cyc - t0, UV_DLY_CYC - 5, UV_DLY_CYC + 10, "uv delay");
    chk(uvt, 1'b1, "uv flag");
    chk(hs | ls, 1'b0, "uv gates off");
    t0 = cyc;
    upto(1, 1'b1, HIC + 100);
    chkn(cyc - t0, HIC - 5, HIC + 30, "uv hiccup");
    fbu = 1'b0;
    $display("t_uv done");
  endtask

  task automatic t_oc();
    pwm = 1'b1;
    hso = 1'b1;
    cy(4);
    chk(hs === 1'b0 && ls === 1'b1, 1'b1, "hs cut");
    ticks(2);
    cy(2);
    chk(occ != 3'h0, 1'b1, "oc counted");
    hso = 1'b0;
    ticks(2);
    cy(2);
    chk(occ === 3'h0, 1'b1, "oc cleared");
    hso = 1'b1;
    t0 = cyc;
    upto(2, 1'b0, 5 * DIV);
    chkn(cyc - t0, 3 * DIV - 10, 4 * DIV + 10, "oc shutdown");
    upto(1, 1'b1, HIC + 50);
    upto(2, 1'b0, 5 * DIV);
    hso = 1'b0;
    upto(1, 1'b1, HIC + 50);
    lso = 1'b1;
    cy(4);
    chk(hs | ls, 1'b0, "ls trip");
    lso = 1'b0;
    upto(1, 1'b1, HIC + 100);
    $display("t_oc done");
  endtask

  task automatic t_prot();
    fbo = 1'b1;
    cy(4);
    chk(hs === 1'b0 && ls === 1'b1, 1'b1, "ov clamp");
    chk(ovt, 1'b1, "ov flag");
    fbo = 1'b0;
    fbu = 1'b1;
    cy(4);
    chk(tri_s === 1'b1 && ls === 1'b0, 1'b1, "ov tristate");
    fbu = 1'b0;
    lk = 1'b1;
    ss = SST_3MS;
    cy(5);
    chk(sw_act, 1'b0, "lockout off");
    lk = 1'b0;
    upto(1, 1'b1, HIC + 50);
    upto(1, 1'b0, 3 * SSC + 100);
    chkn(c, 3 * SSC - 10, 3 * SSC + 10, "soft-start 3");
    ot = 1'b1;
    cy(5);
    chk(sw_act, 1'b0, "hot off");
    ot = 1'b0;
    cy(50);
    chk(sw_act, 1'b0, "waits for cooling");
    tr = 1'b1;
    upto(1, 1'b1, 20);
    $display("t_prot done");
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    {arst_n, en, lk, hso, lso, fbo, ot, tr, pwm, run} = '0;
    v1 = 1'b1;
    fbu = 1'b1;
    ocl = OCL_6A;
    ss = SST_1MS;
    div = 16'h00A6;
    mismatches = 0;
    compares = 0;
    cy(6);
    chk(tri_s, 1'b1, "reset tristate");
    chk(pg_oe_n, 1'b0, "reset pg low");
    chk(pg_o, 1'b0, "open drain level");
    arst_n = 1'b1;
    cy(5);
    t_off();
    t_sync();
    t_start();
    t_uv();
    t_oc();
    t_prot();
    conclude();
  end
endmodule

//--- testbench/bfs_sync_src.sv
// external sync source model driving the switching-clock input
`timescale 1ns/1ps
module bfs_sync_src #(
  parameter int HALF_NS = 500
) (
  input wire logic run,
  output logic sync_o
);
  // stands low while stopped so the block really sees no pulses
  initial begin
    sync_o = 1'b0;
    forever begin
      wait (run);
      #(HALF_NS) sync_o = 1'b1;
      #(HALF_NS) sync_o = 1'b0;
    end
  end
endmodule
